/* rtl/sem_pkg.sv */
package sem_pkg;

    // ------------------------------------------------------------
    // Processor I/O addressing
    // ------------------------------------------------------------
    localparam logic [4:0] SEM_CHANNEL     = 5'h0C;
    localparam logic [1:0] SEM_SUB_WRITE   = 2'h0;
    localparam logic [1:0] SEM_SUB_READ    = 2'h2;
    localparam logic [1:0] SEM_SUB_ADDR    = 2'h3;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int         SEM_ADDR_W      = 7;
    localparam int         SEM_WORD_W      = 16;
    localparam int         SEM_DEPTH       = 128;
    localparam int         SEM_CODE_W      = 11;
    localparam logic [6:0] SEM_ADDR_RST    = 7'h00;
    localparam logic [6:0] SEM_ADDR_STEP   = 7'h01;
    localparam logic [15:0] SEM_WORD_RST   = 16'h0000;

    // ------------------------------------------------------------
    // Comparator set point (10 V end of sweep)
    // ------------------------------------------------------------
    localparam logic [10:0] SEM_END_CODE   = 11'h3E8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SEM_CLK_NS        = 100;
    localparam int SEM_LONG_NS       = 5700;
    localparam int SEM_SHORT_NS      = 200;
    localparam int SEM_LONG_CYC      = (SEM_LONG_NS + SEM_CLK_NS - 1) / SEM_CLK_NS;
    localparam int SEM_SHORT_CYC     = (SEM_SHORT_NS + SEM_CLK_NS - 1) / SEM_CLK_NS;
    localparam int SEM_CNT_W         = 8;
    localparam int SEM_GAP_CYC       = 2;

    // ------------------------------------------------------------
    // Trigger modes and sweep states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEM_TRIG_FREE = 2'h0,
        SEM_TRIG_EXT  = 2'h1,
        SEM_TRIG_LINE = 2'h2
    } sem_trig_e;

    typedef enum logic [1:0] {
        SEM_ST_WAIT  = 2'b00,
        SEM_ST_SWEEP = 2'b01,
        SEM_ST_GAP   = 2'b11
    } sem_state_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        strobe;
        logic        write;
        logic [4:0]  channel;
        logic [1:0]  sub;
        logic [15:0] data;
    } sem_io_s;

    typedef struct packed {
        logic        long_pulse;
        logic        short_pulse;
    } sem_timer_out_s;

endpackage

/* rtl/sem_unstable_timer.sv */
`timescale 1ns/1ps
module sem_unstable_timer
    import sem_pkg::*;
#(
    parameter int LONG_CYC  = SEM_LONG_CYC,
    parameter int SHORT_CYC = SEM_SHORT_CYC
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           fire,
    output sem_timer_out_s      pulses
);

    initial begin
        if (LONG_CYC < 1 || LONG_CYC > 255 || SHORT_CYC < 1 || SHORT_CYC > LONG_CYC)
            $error("sem_unstable_timer: bad pulse lengths");
    end

    typedef struct packed {
        logic [7:0] long_cnt;
        logic [7:0] short_cnt;
    } sem_tmr_s;

    sem_tmr_s st_reg;
    sem_tmr_s st_next;

    // ------------------------------------------------------------
    // Two one-shots retriggered together by the comparator edge
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (fire) begin
            st_next.long_cnt  = 8'(LONG_CYC);
            st_next.short_cnt = 8'(SHORT_CYC);
        end else begin
            if (st_reg.long_cnt != 8'h00)
                st_next.long_cnt = st_reg.long_cnt - 8'h01;
            if (st_reg.short_cnt != 8'h00)
                st_next.short_cnt = st_reg.short_cnt - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign pulses.long_pulse  = (st_reg.long_cnt != 8'h00);
    assign pulses.short_pulse = (st_reg.short_cnt != 8'h00);

endmodule // sem_unstable_timer

/* rtl/sem_event_memory.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Writing zero to address subchannel clears latch.
// - Latched address shown binary, bit zero lowest.
// - Each step request adds exactly one, except one made in the same cycle as an address load.
// - RAM holds locations zero through 127.
// - Data write stores word at latched address.
// - Subchannel two read returns addressed word.
// - Buffers pass words both ways across bus.
// - Channel twelve decoder makes separate strobes.
// - Comparator set point 1000 pulses per event.
// - Sweep ends and resets at 10 V.
// - Unstable timer makes 5.7 us, 200 ns.
// - Manual sweep blocks timer address clocking.
// - Sweep indicator drops at crossings, sweep end.
// - External trigger gives one sweep per trigger.
// - Line trigger starts each sweep from mains.
module sem_event_memory
    import sem_pkg::*;
#(
    parameter int               DEPTH     = SEM_DEPTH,
    parameter int               GAP_CYC   = SEM_GAP_CYC,
    parameter logic [10:0]      END_CODE  = SEM_END_CODE
) (
    input  wire logic           CORE_CLK,
    input  wire logic           SYS_RST,
    input  sem_io_s             IO_REQ,
    input  wire logic           STEP_REQ,
    input  wire logic           MANUAL_SWEEP,
    input  sem_trig_e           TRIG_MODE,
    input  wire logic           EXT_TRIG,
    input  wire logic           LINE_TRIG,
    input  wire logic [10:0]    SWEEP_CODE,
    output logic [6:0]          EVENT_ADDRESS_LINES,
    output logic [15:0]         EVENT_WORD_LINES,
    output logic [15:0]         IO_RDATA,
    output logic                IO_RVALID,
    output logic                EVENT_READ_STROBE,
    output logic                EVENT_WRITE_STROBE,
    output logic                COMPARE_PULSE,
    output logic                SWEEP_ACTIVE,
    output logic                SWEEP_RESET,
    output logic                DATA_UNSTABLE
);

    initial begin
        if (DEPTH != (1 << SEM_ADDR_W) || GAP_CYC < 1 || GAP_CYC > 255)
            $error("sem_event_memory: unsupported parameters");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  ext_sync;
        logic [1:0]  line_sync;
        logic        ext_seen;
        logic        line_seen;
        logic        long_seen;
        logic        cmp_seen;
        logic        armed;
        sem_state_e  state;
        logic [7:0]  gap_cnt;
        logic [6:0]  addr;
        logic [15:0] word;
        logic [15:0] rdata;
        logic        rvalid;
        logic        rd_stb;
        logic        wr_stb;
        logic        cmp;
        logic        active;
        logic        sw_reset;
        logic        unstable;
    } sem_state_s;

    sem_state_s     st_reg;
    sem_state_s     st_next;
    logic [15:0]    ram [DEPTH];
    logic [15:0]    ram_q;
    logic           cmp_now;
    logic           dec_hit;
    logic           wr_addr;
    logic           wr_data;
    logic           rd_data;
    sem_timer_out_s tmr;

    // ------------------------------------------------------------
    // Channel 12 decoder
    // ------------------------------------------------------------
    assign dec_hit = IO_REQ.strobe && (IO_REQ.channel == SEM_CHANNEL);
    assign wr_addr = dec_hit && IO_REQ.write && (IO_REQ.sub == SEM_SUB_ADDR);
    assign wr_data = dec_hit && IO_REQ.write && (IO_REQ.sub == SEM_SUB_WRITE);
    assign rd_data = dec_hit && !IO_REQ.write && (IO_REQ.sub == SEM_SUB_READ);

    // ------------------------------------------------------------
    // End-of-sweep comparator
    // ------------------------------------------------------------
    assign cmp_now = (SWEEP_CODE >= END_CODE);

    // ------------------------------------------------------------
    // Sweep event RAM
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (wr_data)
            ram[st_reg.addr] <= IO_REQ.data;
    end

    assign ram_q = ram[st_reg.addr];

    sem_unstable_timer #(
        .LONG_CYC  (SEM_LONG_CYC),
        .SHORT_CYC (SEM_SHORT_CYC)
    ) u_timer (
        .clk    (CORE_CLK),
        .rst    (SYS_RST),
        .fire   (cmp_now && !st_reg.cmp_seen),
        .pulses (tmr)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next           = st_reg;
        st_next.ext_sync  = {st_reg.ext_sync[0], EXT_TRIG};
        st_next.line_sync = {st_reg.line_sync[0], LINE_TRIG};
        st_next.ext_seen  = st_reg.ext_sync[1];
        st_next.line_seen = st_reg.line_sync[1];
        st_next.cmp_seen  = cmp_now;
        st_next.long_seen = tmr.long_pulse;
        st_next.rd_stb    = rd_data;
        st_next.wr_stb    = wr_data;
        st_next.rvalid    = rd_data;
        st_next.word      = ram_q;
        st_next.cmp       = cmp_now;
        st_next.unstable  = tmr.long_pulse || tmr.short_pulse;
        st_next.sw_reset  = 1'b0;

        if (rd_data)
            st_next.rdata = ram_q;

        if (wr_addr)
            st_next.addr = IO_REQ.data[6:0];
        else if (STEP_REQ)
            st_next.addr = st_reg.addr + SEM_ADDR_STEP;
        else if (!MANUAL_SWEEP && st_reg.long_seen && !tmr.long_pulse)
            st_next.addr = st_reg.addr + SEM_ADDR_STEP;

        // Only the pin of the selected mode may arm a sweep
        if ((TRIG_MODE == SEM_TRIG_EXT) && st_reg.ext_sync[1] && !st_reg.ext_seen)
            st_next.armed = 1'b1;
        if ((TRIG_MODE == SEM_TRIG_LINE) && st_reg.line_sync[1] && !st_reg.line_seen)
            st_next.armed = 1'b1;

        unique case (st_reg.state)
            SEM_ST_WAIT: begin
                st_next.active = 1'b0;
                if (MANUAL_SWEEP) begin
                    st_next.armed = 1'b0;
                end else if (TRIG_MODE == SEM_TRIG_FREE) begin
                    st_next.state  = SEM_ST_SWEEP;
                    st_next.active = 1'b1;
                end else if (st_reg.armed) begin
                    st_next.armed  = 1'b0;
                    st_next.state  = SEM_ST_SWEEP;
                    st_next.active = 1'b1;
                end
            end
            SEM_ST_SWEEP: begin
                st_next.active = 1'b1;
                if (cmp_now && !st_reg.cmp_seen) begin
                    st_next.state    = SEM_ST_GAP;
                    st_next.active   = 1'b0;
                    st_next.sw_reset = 1'b1;
                    st_next.gap_cnt  = 8'(GAP_CYC);
                    st_next.armed    = 1'b0;
                end else if (tmr.short_pulse) begin
                    st_next.active = 1'b0;
                end
            end
            SEM_ST_GAP: begin
                st_next.active = 1'b0;
                if (st_reg.gap_cnt > 8'h01)
                    st_next.gap_cnt = st_reg.gap_cnt - 8'h01;
                else
                    st_next.state = SEM_ST_WAIT;
            end
            default: begin
                st_next.state  = SEM_ST_WAIT;
                st_next.active = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_reg       <= '0;
            st_reg.addr  <= SEM_ADDR_RST;
            st_reg.word  <= SEM_WORD_RST;
            st_reg.state <= SEM_ST_WAIT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign EVENT_ADDRESS_LINES = st_reg.addr;
    assign EVENT_WORD_LINES    = st_reg.word;
    assign IO_RDATA            = st_reg.rdata;
    assign IO_RVALID           = st_reg.rvalid;
    assign EVENT_READ_STROBE   = st_reg.rd_stb;
    assign EVENT_WRITE_STROBE  = st_reg.wr_stb;
    assign COMPARE_PULSE       = st_reg.cmp;
    assign SWEEP_ACTIVE        = st_reg.active;
    assign SWEEP_RESET         = st_reg.sw_reset;
    assign DATA_UNSTABLE       = st_reg.unstable;

endmodule // sem_event_memory

/* test/sem_event_memory_assertions.sv */
`timescale 1ns/1ps
module sem_event_memory_assertions
    import sem_pkg::*;
#(
    parameter logic [10:0] END_CODE = SEM_END_CODE
) (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  sem_io_s          IO_REQ,
    input  wire logic        STEP_REQ,
    input  wire logic        MANUAL_SWEEP,
    input  wire logic [10:0] SWEEP_CODE,
    input  wire logic [6:0]  EVENT_ADDRESS_LINES,
    input  wire logic [15:0] IO_RDATA,
    input  wire logic        IO_RVALID,
    input  wire logic        EVENT_READ_STROBE,
    input  wire logic        EVENT_WRITE_STROBE,
    input  wire logic        COMPARE_PULSE,
    input  wire logic        SWEEP_ACTIVE,
    input  wire logic        SWEEP_RESET,
    input  wire logic        DATA_UNSTABLE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    logic [7:0] hi_cnt_reg;
    wire        sel = IO_REQ.strobe && IO_REQ.channel == SEM_CHANNEL;
    wire        ld  = sel && IO_REQ.write && IO_REQ.sub == SEM_SUB_ADDR;
    wire        rd  = sel && !IO_REQ.write && IO_REQ.sub == SEM_SUB_READ;
    wire        wr  = sel && IO_REQ.write && IO_REQ.sub == SEM_SUB_WRITE;
    // Counts the cycles of the current unstable pulse
    always_ff @(posedge CORE_CLK) begin
        hi_cnt_reg <= (SYS_RST || !DATA_UNSTABLE) ? 8'h00 : hi_cnt_reg + 8'h01;
    end
    addr_load_a: assert property (ld |=> EVENT_ADDRESS_LINES == $past(IO_REQ.data[6:0]))
        else $error("address load wrong");
    step_inc_a: assert property (STEP_REQ && !ld |=> EVENT_ADDRESS_LINES == $past(EVENT_ADDRESS_LINES) + 7'h01)
        else $error("address step wrong");
    manual_hold_a: assert property (MANUAL_SWEEP && $past(MANUAL_SWEEP) && !STEP_REQ && !ld |=> $stable(EVENT_ADDRESS_LINES))
        else $error("address moved in manual");
    wr_strobe_a: assert property (wr |=> EVENT_WRITE_STROBE)
        else $error("write strobe missing");
    rd_cause_a: assert property (EVENT_READ_STROBE |-> $past(rd))
        else $error("read strobe without request");
    rd_valid_a: assert property (rd |=> IO_RVALID && EVENT_READ_STROBE)
        else $error("read answer missing");
    rdata_hold_a: assert property (!IO_RVALID |-> $stable(IO_RDATA))
        else $error("read data changed");
    cmp_level_a: assert property (COMPARE_PULSE == ($past(SWEEP_CODE) >= END_CODE))
        else $error("comparator wrong");
    sweep_end_a: assert property (SWEEP_RESET |-> !SWEEP_ACTIVE ##1 !SWEEP_RESET)
        else $error("sweep end wrong");
    active_drop_a: assert property ($rose(COMPARE_PULSE) |-> ##[1:4] !SWEEP_ACTIVE)
        else $error("sweep indicator stayed up");
    unstable_go_a: assert property ($rose(COMPARE_PULSE) |-> ##[1:3] DATA_UNSTABLE)
        else $error("timer did not fire");
    pulse_width_a: assert property ($fell(DATA_UNSTABLE) |-> hi_cnt_reg == SEM_LONG_CYC)
        else $error("timer width wrong");
endmodule // sem_event_memory_assertions

bind sem_event_memory sem_event_memory_assertions #(.END_CODE(END_CODE)) i_chk (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .IO_REQ(IO_REQ), .STEP_REQ(STEP_REQ),
    .MANUAL_SWEEP(MANUAL_SWEEP), .SWEEP_CODE(SWEEP_CODE), .EVENT_ADDRESS_LINES(EVENT_ADDRESS_LINES),
    .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .EVENT_READ_STROBE(EVENT_READ_STROBE),
    .EVENT_WRITE_STROBE(EVENT_WRITE_STROBE), .COMPARE_PULSE(COMPARE_PULSE),
    .SWEEP_ACTIVE(SWEEP_ACTIVE), .SWEEP_RESET(SWEEP_RESET), .DATA_UNSTABLE(DATA_UNSTABLE));

/* test/sem_cpu_model.sv */
`timescale 1ns/1ps
module sem_cpu_model
    import sem_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic [15:0] IO_RDATA,
    input  wire logic        IO_RVALID,
    output sem_io_s          IO_REQ
);
    initial IO_REQ = '0;
    // One request held over one rising edge; answer taken one cycle later
    task automatic io(input logic w, input logic [4:0] ch, input logic [1:0] s, input logic [15:0] d,
                      output logic [15:0] rd, output logic rv);
        @(negedge CORE_CLK);
        IO_REQ = '{strobe: 1'b1, write: w, channel: ch, sub: s, data: d};
        @(negedge CORE_CLK);
        rd = IO_RDATA;
        rv = IO_RVALID;
        IO_REQ.strobe = 1'b0;
        // Released bus shows no stale word
        IO_REQ.data = ~d;
    endtask
endmodule // sem_cpu_model

/* test/sweep_event_memory_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module sweep_event_memory_tb
    import sem_pkg::*;
;
    typedef struct { logic [6:0] a; logic [15:0] d; } sem_row_s;
    logic        core_clk, sys_rst, step_req, manual_sweep, ext_trig, line_trig;
    logic        io_rvalid, rd_strobe, wr_strobe, cmp, active, sw_reset, unstable, rv, seen;
    logic [10:0] sweep_code;
    logic [6:0]  addr;
    logic [15:0] word, io_rdata, rd;
    sem_trig_e   trig_mode;
    sem_io_s     io_req;
    int          errors, checks_done, cycles;
    sem_row_s    rows [0:7] = '{'{7'h01, 16'hFFFF}, '{7'h02, 16'h0001}, '{7'h04, 16'h8000}, '{7'h08, 16'hA5A5},
                                '{7'h10, 16'h5A5A}, '{7'h20, 16'h0F0F}, '{7'h40, 16'hF0F0}, '{7'h7F, 16'h1234}};

    sem_event_memory i_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .IO_REQ(io_req), .STEP_REQ(step_req),
        .MANUAL_SWEEP(manual_sweep), .TRIG_MODE(trig_mode), .EXT_TRIG(ext_trig), .LINE_TRIG(line_trig),
        .SWEEP_CODE(sweep_code), .EVENT_ADDRESS_LINES(addr), .EVENT_WORD_LINES(word), .IO_RDATA(io_rdata),
        .IO_RVALID(io_rvalid), .EVENT_READ_STROBE(rd_strobe), .EVENT_WRITE_STROBE(wr_strobe),
        .COMPARE_PULSE(cmp), .SWEEP_ACTIVE(active), .SWEEP_RESET(sw_reset), .DATA_UNSTABLE(unstable));
    sem_cpu_model i_cpu (.CORE_CLK(core_clk), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid), .IO_REQ(io_req));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wait_active(input logic lvl);
        repeat (12) if (active !== lvl) @(negedge core_clk);
        `CHK("sweep_active", lvl, active)
    endtask
    // Drive the sweep to its end point and look for the end pulse
    task automatic sweep_end();
        @(negedge core_clk);
        sweep_code = 11'h3E8;
        seen = 1'b0;
        repeat (3) begin
            @(negedge core_clk);
            seen |= sw_reset;
        end
        `CHK("sweep_reset", 1'b1, seen)
        `CHK("sweep_active", 1'b0, active)
        sweep_code = 11'h000;
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        sys_rst = 1'b1; step_req = 1'b0; manual_sweep = 1'b1; trig_mode = SEM_TRIG_FREE;
        ext_trig = 1'b0; line_trig = 1'b0; sweep_code = 11'h000;
        errors = 0; checks_done = 0; cycles = 0;
        repeat (8) @(negedge core_clk);
        `CHK("address", 7'h00, addr)
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            i_cpu.io(1'b1, SEM_CHANNEL, SEM_SUB_ADDR, {9'h000, rows[i].a}, rd, rv);
            `CHK("address", rows[i].a, addr)
            i_cpu.io(1'b1, SEM_CHANNEL, SEM_SUB_WRITE, rows[i].d, rd, rv);
            `CHK("write_strobe", 1'b1, wr_strobe)
        end
        foreach (rows[i]) begin
            i_cpu.io(1'b1, SEM_CHANNEL, SEM_SUB_ADDR, {9'h1FF, rows[i].a}, rd, rv);
            `CHK("address", rows[i].a, addr)
            i_cpu.io(1'b0, SEM_CHANNEL, SEM_SUB_READ, 16'h0000, rd, rv);
            `CHK("read_data", rows[i].d, rd)
            `CHK("read_valid", 1'b1, rv & rd_strobe)
            `CHK("word_lines", rows[i].d, word)
        end
        i_cpu.io(1'b1, 5'h0B, SEM_SUB_ADDR, 16'h0003, rd, rv);
        `CHK("address", 7'h7F, addr)
        i_cpu.io(1'b1, SEM_CHANNEL, SEM_SUB_ADDR, 16'h000F, rd, rv);
        step_req = 1'b1;
        @(negedge core_clk);
        step_req = 1'b0;
        @(negedge core_clk);
        `CHK("address", 7'h10, addr)
        i_cpu.io(1'b1, SEM_CHANNEL, SEM_SUB_ADDR, 16'h0000, rd, rv);
        `CHK("address", 7'h00, addr)
        i_cpu.io(1'b1, SEM_CHANNEL, SEM_SUB_ADDR, 16'h0005, rd, rv);
        sweep_code = 11'h3E8;
        repeat (2) @(negedge core_clk);
        `CHK("compare_pulse", 1'b1, cmp)
        `CHK("data_unstable", 1'b1, unstable)
        repeat (56) @(negedge core_clk);
        `CHK("data_unstable", 1'b1, unstable)
        @(negedge core_clk);
        `CHK("data_unstable", 1'b0, unstable)
        repeat (11) @(negedge core_clk);
        sweep_code = 11'h000;
        `CHK("address", 7'h05, addr)
        manual_sweep = 1'b0;
        wait_active(1'b1);
        sweep_end();
        repeat (62) @(negedge core_clk);
        `CHK("address", 7'h06, addr)
        wait_active(1'b1);
        // End the free-running sweep with external mode selected
        trig_mode = SEM_TRIG_EXT;
        sweep_end();
        for (int m = 1; m <= 2; m++) begin
            trig_mode = sem_trig_e'(m);
            // The pin of the other mode must not start a sweep
            ext_trig = (m == 2);
            line_trig = (m == 1);
            repeat (70) @(negedge core_clk);
            `CHK("sweep_active", 1'b0, active)
            ext_trig = (m == 1);
            line_trig = (m == 2);
            repeat (2) @(negedge core_clk);
            ext_trig = 1'b0;
            line_trig = 1'b0;
            wait_active(1'b1);
            sweep_end();
            repeat (70) @(negedge core_clk);
            `CHK("sweep_active", 1'b0, active)
        end
        complete_run();
    end
endmodule // sweep_event_memory_tb
